// ==== src/dtio_pkg.sv ====
// constants, carriers and state layout of the drive terminal i/o logic
// assumes a 100 MHz clock and a classic wishbone master with 32-bit data
// Contract
// - terminal code 17 inactive picks primary frequency source, active picks secondary.
// - terminal code 18 active bypasses the pid mode setting.
// - terminal code 19 active forces the pid integral to zero.
// - terminal code 20 acts as the panel reset key only while active.
// - code 23 conducting with pid enabled inverts the pid characteristic.
// - only the sixth terminal counts pulses with code 28, on each falling edge.
// - any terminal with code 29 active holds counter cleared, counting resumes after.
// - terminals sampled every 2 ms; new level after N equal samples, N 1..200.
// - step size zero ramps setpoint continuously while up or down is active.
// - nonzero step moves one step per press; held over 2 s ramps continuously.
// - hold mode 0 holds and ignores keys stopped, 1 zeroes, 2 holds and keeps keys.
// - hold mode 0 starts at first preset, saves setpoint there at run removal.
// - each relay follows a selectable status condition code 0 to 15.
// - relay code 3 is on while output frequency is within reached setting plus or minus range.
// - relay code 4 on above the reached setting, code 5 on below it.
// - one polarity bit per terminal, 0 normally open, 1 normally closed.
// - relay code 14 on after current exceeds level for detect time, 100 ms off delay.
// - traverse starts only when running, code 25 active, and center frequency reached.
// - traverse ramps use traverse times; accel on approach, decel when disabled or stopped.
// - code 26 shifts center up, code 27 down; both together keep the center.
// - up and down active together is invalid and changes nothing.
package dtio_pkg;
	localparam int NUM_IN = 6;
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCAN_PERIOD_NS = 2000000;
	localparam int SCAN_CYCLES_DFLT = SCAN_PERIOD_NS / CLK_PERIOD_NS;
	localparam int SCAN_MS = 2;
	localparam int HOLD_MS = 2000;
	localparam int RELAY_OFF_MS = 100;
	localparam int CUR_UNIT_MS = 100;
	localparam logic [10:0] HOLD_TICKS = 11'(HOLD_MS / SCAN_MS);
	localparam logic [5:0] OFF_TICKS = 6'(RELAY_OFF_MS / SCAN_MS);
	localparam logic [5:0] CUR_UNIT_TICKS = 6'(CUR_UNIT_MS / SCAN_MS);
	// terminal function codes
	localparam logic [4:0] FN_UP = 5'h0F;
	localparam logic [4:0] FN_DOWN = 5'h10;
	localparam logic [4:0] FN_FREQ_SEC = 5'h11;
	localparam logic [4:0] FN_PID_OFF = 5'h12;
	localparam logic [4:0] FN_PID_ICLR = 5'h13;
	localparam logic [4:0] FN_RESET = 5'h14;
	localparam logic [4:0] FN_PID_INV = 5'h17;
	localparam logic [4:0] FN_TRAV_EN = 5'h19;
	localparam logic [4:0] FN_TRAV_UP = 5'h1A;
	localparam logic [4:0] FN_TRAV_DN = 5'h1B;
	localparam logic [4:0] FN_COUNT = 5'h1C;
	localparam logic [4:0] FN_CNT_CLR = 5'h1D;
	// relay condition codes computed here
	localparam logic [3:0] RC_BAND = 4'h3;
	localparam logic [3:0] RC_ABOVE = 4'h4;
	localparam logic [3:0] RC_BELOW = 4'h5;
	localparam logic [3:0] RC_CURRENT = 4'hE;
	// up/down hold modes
	localparam logic [1:0] HOLD_STOP_IDLE = 2'h0;
	localparam logic [1:0] HOLD_ZERO = 2'h1;
	localparam logic [1:0] HOLD_KEEP = 2'h2;
	// register byte offsets
	localparam logic [7:0] REG_FUNC = 8'h00;
	localparam logic [7:0] REG_SCAN = 8'h04;
	localparam logic [7:0] REG_POL = 8'h08;
	localparam logic [7:0] REG_UPDN = 8'h0C;
	localparam logic [7:0] REG_RELAY = 8'h10;
	localparam logic [7:0] REG_FREQ = 8'h14;
	localparam logic [7:0] REG_CURR = 8'h18;
	localparam logic [7:0] REG_PRESET = 8'h1C;
	localparam logic [7:0] REG_TRAV = 8'h20;
	localparam logic [7:0] REG_TDEV = 8'h24;
	localparam logic [7:0] REG_STAT = 8'h28;
	localparam logic [7:0] REG_COUNT = 8'h2C;
	// field positions and reset values
	localparam int POL_HIGH_POS = 8;
	localparam int HOLD_POS = 16;
	localparam int RC2_POS = 8;
	localparam int RELAY_POS = 8;
	localparam int TRAV_POS = 12;
	localparam int FSEC_POS = 16;
	localparam logic [7:0] SCAN_N_RST = 8'h01;

	typedef enum logic [1:0] {RAMP_ACC, RAMP_DEC, RAMP_TUP, RAMP_TDN} dtio_ramp_t;

	typedef struct packed {
		logic run;
		logic pid_en;
		logic [15:0] fout;
		logic [15:0] iout;
		logic [15:0] status;
	} dtio_drive_t;

	typedef struct packed {
		logic freq_sec;
		logic pid_bypass;
		logic pid_iclr;
		logic fault_reset;
		logic pid_invert;
		logic cnt_cleared;
		logic trav_active;
		dtio_ramp_t ramp;
		logic [15:0] setpoint;
		logic [15:0] count;
		logic [15:0] trav_center;
	} dtio_ctl_t;

	typedef struct packed {
		logic [NUM_IN-1:0][4:0] func;
		logic [7:0] scan_n;
		logic [8:0] pol;
		logic [9:0] step;
		logic [1:0] hold;
		logic [3:0] rc1;
		logic [3:0] rc2;
		logic [15:0] f_reach;
		logic [15:0] f_range;
		logic [15:0] i_level;
		logic [15:0] i_time;
		logic [15:0] preset;
		logic [15:0] center;
		logic [15:0] dev_up;
		logic [15:0] dev_dn;
	} dtio_cfg_t;

	typedef struct packed {
		dtio_cfg_t cfg;
		logic [23:0] div;
		logic tick;
		logic [NUM_IN-1:0] s1;
		logic [NUM_IN-1:0] s2;
		logic [NUM_IN-1:0] s3;
		logic [NUM_IN-1:0] lvl;
		logic [NUM_IN-1:0][7:0] dbc;
		logic [NUM_IN-1:0] act;
		logic [NUM_IN-1:0] prev;
		logic run_prev;
		logic [10:0] hold_cnt;
		logic [21:0] i_cnt;
		logic [5:0] off_cnt;
		logic cur_reached;
		logic [1:0] relay;
		dtio_ctl_t ctl;
		logic ack;
		logic [31:0] dat;
	} dtio_state_t;
endpackage

// ==== src/dtio_top.sv ====
// drive terminal i/o logic: debounce, terminal functions, up/down setpoint, relays
// assumes drive status on the same clock and a classic wishbone master
//
// The Wishbone register port and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
module dtio_top import dtio_pkg::*; #(
	parameter int SCAN_CYCLES = SCAN_CYCLES_DFLT,
	parameter logic [15:0] FREQ_MAX = 16'h9C40,
	parameter logic [15:0] UD_RATE = 16'h0001
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// field terminals and drive status
	input wire logic [NUM_IN-1:0] multifunction_inputs_i,
	input wire dtio_drive_t drive_i,
	// control to the drive and relays
	output dtio_ctl_t ctl_o,
	output logic output_relay_one_o,
	output logic output_relay_two_o
);
	dtio_state_t q;
	dtio_state_t d;
	logic [31:0] hit;
	logic band_ok;
	logic above_ok;
	logic below_ok;

	function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {1'b0, a} + {1'b0, b};
		sat_add = (s > {1'b0, FREQ_MAX}) ? FREQ_MAX : s[15:0];
	endfunction

	function automatic logic [15:0] sat_sub(input logic [15:0] a, input logic [15:0] b);
		sat_sub = (a > b) ? a - b : 16'h0000;
	endfunction

	function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n,
			input logic [3:0] sel);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = n[b*8 +: 8];
			end
		end
		wmerge = r;
	endfunction

	function automatic logic relay_eval(input logic [3:0] code, input logic band,
			input logic above, input logic below, input logic cur, input logic [15:0] st);
		unique case (code)
			RC_BAND: relay_eval = band;
			RC_ABOVE: relay_eval = above;
			RC_BELOW: relay_eval = below;
			RC_CURRENT: relay_eval = cur;
			default: relay_eval = st[code];
		endcase
	endfunction

	// which function codes are asserted by any debounced terminal
	always_comb begin
		hit = '0;
		for (int i = 0; i < NUM_IN; i++) begin
			if (q.act[i]) begin
				hit[q.cfg.func[i]] = 1'b1;
			end
		end
	end

	// frequency comparisons shared by both relays
	always_comb begin
		band_ok = (drive_i.fout >= q.cfg.f_reach) ?
			(drive_i.fout - q.cfg.f_reach) <= q.cfg.f_range :
			(q.cfg.f_reach - drive_i.fout) <= q.cfg.f_range;
		above_ok = drive_i.fout > q.cfg.f_reach;
		below_ok = drive_i.fout < q.cfg.f_reach;
	end

	// next-state logic for the whole block
	always_comb begin
		logic [NUM_IN-1:0] sample;
		logic [7:0] scan_n;
		logic up;
		logic dn;
		logic one_key;
		logic ud_ok;
		logic trav_en;
		logic [21:0] i_limit;
		logic [31:0] rd;
		logic [31:0] w;
		sample = '0;
		scan_n = 8'h00;
		up = 1'b0;
		dn = 1'b0;
		one_key = 1'b0;
		ud_ok = 1'b0;
		trav_en = 1'b0;
		i_limit = '0;
		rd = 32'h0000_0000;
		w = 32'h0000_0000;
		d = q;
		d.tick = 1'b0;
		d.ack = 1'b0;

		// free-running scan divider, one tick per period
		if (q.div == 24'(SCAN_CYCLES - 1)) begin
			d.div = '0;
			d.tick = 1'b1;
		end else begin
			d.div = q.div + 24'h000001;
		end

		// pin synchroniser; a change counts once stages two and three agree
		d.s1 = multifunction_inputs_i;
		d.s2 = q.s1;
		d.s3 = q.s2;
		d.lvl = (q.s2 & q.s3) | (q.lvl & (q.s2 ^ q.s3));

		// polarity first, so debounce and functions see active-high levels
		sample = q.lvl ^ q.cfg.pol[NUM_IN-1:0];
		scan_n = (q.cfg.scan_n == 8'h00) ? SCAN_N_RST : q.cfg.scan_n;
		if (q.tick) begin
			d.prev = q.act;
			for (int i = 0; i < NUM_IN; i++) begin
				if (sample[i] == q.act[i]) begin
					d.dbc[i] = 8'h00;
				end else if ({1'b0, q.dbc[i]} + 9'h001 >= {1'b0, scan_n}) begin
					d.act[i] = sample[i];
					d.dbc[i] = 8'h00;
				end else begin
					d.dbc[i] = q.dbc[i] + 8'h01;
				end
			end
		end

		// level functions towards the drive
		d.ctl.freq_sec = hit[FN_FREQ_SEC];
		d.ctl.pid_bypass = hit[FN_PID_OFF];
		d.ctl.pid_iclr = hit[FN_PID_ICLR];
		d.ctl.fault_reset = hit[FN_RESET];
		d.ctl.pid_invert = hit[FN_PID_INV] & drive_i.pid_en;
		d.ctl.cnt_cleared = hit[FN_CNT_CLR];

		// pulse counter; other terminals set to the count code are ignored
		if (hit[FN_CNT_CLR]) begin
			d.ctl.count = 16'h0000;
		end else if (q.tick && q.cfg.func[NUM_IN-1] == FN_COUNT &&
				q.prev[NUM_IN-1] && !q.act[NUM_IN-1]) begin
			d.ctl.count = q.ctl.count + 16'h0001;
		end

		// up/down setpoint, handled once per scan tick
		up = hit[FN_UP];
		dn = hit[FN_DOWN];
		one_key = up ^ dn;
		ud_ok = drive_i.run || q.cfg.hold == HOLD_KEEP;
		if (q.tick) begin
			d.run_prev = drive_i.run;
			if (!one_key) begin
				d.hold_cnt = 11'h000;
			end else if (q.hold_cnt != HOLD_TICKS) begin
				d.hold_cnt = q.hold_cnt + 11'h001;
			end
			if (drive_i.run && !q.run_prev) begin
				if (q.cfg.hold == HOLD_STOP_IDLE) begin
					d.ctl.setpoint = q.cfg.preset;
				end else if (q.cfg.hold == HOLD_ZERO) begin
					d.ctl.setpoint = 16'h0000;
				end
			end else if (!drive_i.run && q.run_prev) begin
				if (q.cfg.hold == HOLD_ZERO) begin
					d.ctl.setpoint = 16'h0000;
				end
			end else if (ud_ok && one_key) begin
				if (q.cfg.step == 10'h000 || q.hold_cnt == HOLD_TICKS) begin
					d.ctl.setpoint = up ? sat_add(q.ctl.setpoint, UD_RATE) :
						sat_sub(q.ctl.setpoint, UD_RATE);
				end else if (q.hold_cnt == 11'h000) begin
					d.ctl.setpoint = up ? sat_add(q.ctl.setpoint, 16'(q.cfg.step)) :
						sat_sub(q.ctl.setpoint, 16'(q.cfg.step));
				end
			end
		end

		// current reached: on-delay by detect time, fixed off-delay
		i_limit = 22'(q.cfg.i_time) * 22'(CUR_UNIT_TICKS);
		if (q.tick) begin
			if (drive_i.iout > q.cfg.i_level) begin
				d.off_cnt = 6'h00;
				if (q.i_cnt >= i_limit) begin
					d.cur_reached = 1'b1;
				end else begin
					d.i_cnt = q.i_cnt + 22'h000001;
				end
			end else begin
				d.i_cnt = 22'h000000;
				if (q.cur_reached) begin
					if (q.off_cnt == OFF_TICKS - 6'h01) begin
						d.cur_reached = 1'b0;
						d.off_cnt = 6'h00;
					end else begin
						d.off_cnt = q.off_cnt + 6'h01;
					end
				end
			end
		end
		d.relay[0] = relay_eval(q.cfg.rc1, band_ok, above_ok, below_ok, q.cur_reached,
			drive_i.status);
		d.relay[1] = relay_eval(q.cfg.rc2, band_ok, above_ok, below_ok, q.cur_reached,
			drive_i.status);

		// traverse: center shift, start condition and ramp choice
		unique case ({hit[FN_TRAV_UP], hit[FN_TRAV_DN]})
			2'b10: d.ctl.trav_center = sat_add(q.cfg.center, q.cfg.dev_up);
			2'b01: d.ctl.trav_center = sat_sub(q.cfg.center, q.cfg.dev_dn);
			default: d.ctl.trav_center = q.cfg.center;
		endcase
		trav_en = drive_i.run && hit[FN_TRAV_EN];
		if (!trav_en) begin
			d.ctl.trav_active = 1'b0;
		end else if (drive_i.fout >= q.cfg.center) begin
			d.ctl.trav_active = 1'b1;
		end
		if (!trav_en) begin
			d.ctl.ramp = RAMP_DEC;
		end else if (!q.ctl.trav_active) begin
			d.ctl.ramp = RAMP_ACC;
		end else if (drive_i.fout < q.ctl.trav_center) begin
			d.ctl.ramp = RAMP_TUP;
		end else begin
			d.ctl.ramp = RAMP_TDN;
		end

		// register read view; unmapped offsets read zero
		unique case (wb_adr_i)
			REG_FUNC: rd = 32'(q.cfg.func);
			REG_SCAN: rd = 32'(q.cfg.scan_n);
			REG_POL: rd = {20'h00000, q.cfg.pol[8:5], 3'h0, q.cfg.pol[4:0]};
			REG_UPDN: rd = {14'h0000, q.cfg.hold, 6'h00, q.cfg.step};
			REG_RELAY: rd = {20'h00000, q.cfg.rc2, 4'h0, q.cfg.rc1};
			REG_FREQ: rd = {q.cfg.f_range, q.cfg.f_reach};
			REG_CURR: rd = {q.cfg.i_time, q.cfg.i_level};
			REG_PRESET: rd = {16'h0000, q.cfg.preset};
			REG_TRAV: rd = {16'h0000, q.cfg.center};
			REG_TDEV: rd = {q.cfg.dev_dn, q.cfg.dev_up};
			REG_STAT: begin
				rd[NUM_IN-1:0] = q.act;
				rd[RELAY_POS +: 2] = q.relay;
				rd[TRAV_POS] = q.ctl.trav_active;
				rd[FSEC_POS] = q.ctl.freq_sec;
			end
			REG_COUNT: rd = {q.ctl.setpoint, q.ctl.count};
			default: rd = 32'h0000_0000;
		endcase

		// wishbone: one-cycle ack, gap forced by the ack itself
		if (wb_cyc_i && wb_stb_i && !q.ack) begin
			d.ack = 1'b1;
			d.dat = wb_we_i ? 32'h0000_0000 : rd;
			w = wmerge(rd, wb_dat_i, wb_sel_i);
			if (wb_we_i) begin
				unique case (wb_adr_i)
					REG_FUNC: d.cfg.func = w[NUM_IN*5-1:0];
					REG_SCAN: d.cfg.scan_n = w[7:0];
					REG_POL: d.cfg.pol = {w[POL_HIGH_POS +: 4], w[4:0]};
					REG_UPDN: begin
						d.cfg.step = w[9:0];
						d.cfg.hold = w[HOLD_POS +: 2];
					end
					REG_RELAY: begin
						d.cfg.rc1 = w[3:0];
						d.cfg.rc2 = w[RC2_POS +: 4];
					end
					REG_FREQ: begin
						d.cfg.f_reach = w[15:0];
						d.cfg.f_range = w[31:16];
					end
					REG_CURR: begin
						d.cfg.i_level = w[15:0];
						d.cfg.i_time = w[31:16];
					end
					REG_PRESET: d.cfg.preset = w[15:0];
					REG_TRAV: d.cfg.center = w[15:0];
					REG_TDEV: begin
						d.cfg.dev_up = w[15:0];
						d.cfg.dev_dn = w[31:16];
					end
					default: d.cfg = d.cfg;
				endcase
			end
		end

		// saving at run removal wins over a bus write in the same cycle
		if (q.tick && !drive_i.run && q.run_prev && q.cfg.hold == HOLD_STOP_IDLE) begin
			d.cfg.preset = q.ctl.setpoint;
		end
	end

	// single state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '0;
			q.cfg.scan_n <= SCAN_N_RST;
		end else begin
			q <= d;
		end
	end

	// outputs straight from the state register
	assign wb_ack_o = q.ack;
	assign wb_dat_o = q.dat;
	assign ctl_o = q.ctl;
	assign output_relay_one_o = q.relay[0];
	assign output_relay_two_o = q.relay[1];

	// checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_count_fall;
		q.tick && q.cfg.func[NUM_IN-1] == FN_COUNT && q.prev[NUM_IN-1] &&
			!q.act[NUM_IN-1] && !hit[FN_CNT_CLR];
	endsequence

	sequence s_both_keys;
		q.tick && hit[FN_UP] && hit[FN_DOWN] && drive_i.run == q.run_prev;
	endsequence

	freq_select_a: assert property (
		##1 ctl_o.freq_sec == $past(hit[FN_FREQ_SEC]))
		else $error("frequency source select does not follow terminal");
	pid_invert_a: assert property (
		ctl_o.pid_invert |-> $past(drive_i.pid_en) && $past(hit[FN_PID_INV]))
		else $error("pid invert without enable or terminal");
	count_step_a: assert property (
		s_count_fall |=> ctl_o.count == $past(q.ctl.count) + 16'h0001)
		else $error("pulse counter missed a falling edge");
	count_clear_a: assert property (
		hit[FN_CNT_CLR] |=> ctl_o.count == 16'h0000 && ctl_o.cnt_cleared)
		else $error("counter not held clear");
	debounce_tick_a: assert property (
		!q.tick |=> $stable(q.act))
		else $error("debounced level changed off the scan tick");
	tick_gap_a: assert property (
		q.tick |=> !q.tick [*8])
		else $error("scan ticks too close");
	both_keys_a: assert property (
		s_both_keys |=> $stable(ctl_o.setpoint))
		else $error("setpoint moved with both keys active");
	band_relay_a: assert property (
		q.cfg.rc1 == RC_BAND |=> output_relay_one_o == $past(band_ok))
		else $error("relay one band compare wrong");
	above_relay_a: assert property (
		q.cfg.rc2 == RC_ABOVE |=> output_relay_two_o == $past(above_ok))
		else $error("relay two threshold compare wrong");
	current_off_a: assert property (
		$fell(q.cur_reached) |-> $past(q.off_cnt) == OFF_TICKS - 6'h01)
		else $error("current relay released without off delay");
	center_hold_a: assert property (
		hit[FN_TRAV_UP] && hit[FN_TRAV_DN] |=> ctl_o.trav_center == $past(q.cfg.center))
		else $error("center moved with both deviations active");
endmodule
`default_nettype wire

// ==== testbench/dtio_field.sv ====
// field contacts on the terminal block: one switch per input terminal
// assumes the bench says which contacts are pressed and which are wired normally closed
`timescale 1ns/100ps
`default_nettype none
module dtio_field import dtio_pkg::*; (
	// operator side
	input wire logic [NUM_IN-1:0] press_i,
	input wire logic [NUM_IN-1:0] nc_i,
	// terminal pins
	output logic [NUM_IN-1:0] pin_o
);
	// a closed-type contact reads high at rest and opens when pressed
	assign pin_o = press_i ^ nc_i;
endmodule
`default_nettype wire

// ==== testbench/tb_drive_terminal_io_logic.sv ====
// self-checking bench of the terminal i/o logic with field contacts
// assumes a shortened scan divider so that ticks come every SC cycles
`timescale 1ns/100ps
`default_nettype none
module tb_drive_terminal_io_logic import dtio_pkg::*; ;
	localparam int SC = 20;
	typedef struct {logic [3:0] rc; logic [15:0] f; logic [15:0] st; logic y;} dtio_row_t;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [3:0] wsel = 4'hF;
	logic [31:0] dat = 32'h0, rdat, q;
	logic ack, r1, r2;
	logic [NUM_IN-1:0] press = '0, nc = '0, pin;
	dtio_drive_t drv = '0;
	dtio_ctl_t ctl;
	int err_total = 0, comparisons = 0, cyc_cnt = 0;
	logic [15:0] sp;
	// reach 1000 and range 50 give the band 950..1050
	dtio_row_t rows [8] = '{'{4'h3, 16'h041A, 16'h0, 1'b1}, '{4'h3, 16'h041B, 16'h0, 1'b0},
		'{4'h4, 16'h03E9, 16'h0, 1'b1}, '{4'h4, 16'h03E8, 16'h0, 1'b0},
		'{4'h5, 16'h03E7, 16'h0, 1'b1}, '{4'h5, 16'h03E8, 16'h0, 1'b0},
		'{4'h0, 16'h0, 16'h0001, 1'b1}, '{4'hF, 16'h0, 16'h7FFF, 1'b0}};
	dtio_top #(.SCAN_CYCLES(SC)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .multifunction_inputs_i(pin), .drive_i(drv),
		.ctl_o(ctl), .output_relay_one_o(r1), .output_relay_two_o(r2));
	dtio_field i_field (.press_i(press), .nc_i(nc), .pin_o(pin));
	// 100 MHz clock
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	// hang guard, well above the longest sequence
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 60000) begin
			err_total++;
			test_done;
		end
	end
	task automatic test_done;
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %s exp %h seen %h", nm, e, s);
		end
	endtask
	// classic cycle, held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= wsel;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 50)
			chk("ack", 32'h0, 32'h1);
	endtask
	task automatic tk(input int n);
		repeat (n * SC) @(posedge clk_i);
	endtask
	function automatic logic [31:0] fw(input logic [4:0] a, b, c, d, e, f);
		return {2'h0, f, e, d, c, b, a};
	endfunction
	// main sequence
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		chk("ctl_rst", {31'h0, |ctl}, 32'h0);
		wb(0, REG_SCAN, 0);
		chk("scan_rst", q, 32'h1);
		wb(0, REG_POL, 0);
		chk("pol_rst", q, 32'h0);
		wb(1, REG_STAT, 32'hFFFFFFFF);
		wb(0, REG_STAT, 0);
		chk("stat_ro", q, 32'h0);
		wb(0, 8'h30, 0);
		chk("unmapped", q, 32'h0);
		// relay condition table, both relays on the same code
		wb(1, REG_FREQ, 32'h003203E8);
		for (int i = 0; i < 8; i++) begin
			wb(1, REG_RELAY, {20'h0, rows[i].rc, 4'h0, rows[i].rc});
			drv.fout <= rows[i].f;
			drv.status <= rows[i].st;
			repeat (3) @(posedge clk_i);
			chk("relay1", r1, rows[i].y);
			chk("relay2", r2, rows[i].y);
		end
		// byte enables merge into the stored word
		wsel = 4'h3;
		wb(1, REG_FREQ, 32'hFFFF0010);
		wsel = 4'hF;
		wb(0, REG_FREQ, 0);
		chk("byte_sel", q, 32'h00320010);
		// level functions on five terminals
		drv.pid_en <= 1'b1;
		wb(1, REG_FUNC, fw(FN_FREQ_SEC, FN_PID_OFF, FN_PID_ICLR, FN_RESET, FN_PID_INV, FN_COUNT));
		press <= 6'h1F;
		tk(2);
		chk("levels_on", {ctl.freq_sec, ctl.pid_bypass, ctl.pid_iclr, ctl.fault_reset,
			ctl.pid_invert}, 5'h1F);
		press <= 6'h00;
		tk(2);
		chk("levels_off", {ctl.freq_sec, ctl.pid_bypass, ctl.pid_iclr, ctl.fault_reset,
			ctl.pid_invert}, 5'h00);
		// pulse count on the sixth terminal only, then clear
		press[5] <= 1'b1;
		tk(2);
		chk("no_count_on_press", ctl.count, 16'h0);
		press[5] <= 1'b0;
		tk(3);
		chk("count_one", ctl.count, 16'h1);
		wb(1, REG_FUNC, fw(FN_COUNT, 5'h0, 5'h0, 5'h0, FN_CNT_CLR, FN_COUNT));
		press[0] <= 1'b1;
		tk(2);
		press[0] <= 1'b0;
		tk(3);
		chk("count_not_six", ctl.count, 16'h1);
		press[4] <= 1'b1;
		tk(2);
		press[5] <= 1'b1;
		tk(2);
		press[5] <= 1'b0;
		tk(3);
		chk("cleared", {ctl.cnt_cleared, ctl.count}, 17'h10000);
		press[4] <= 1'b0;
		tk(2);
		press[5] <= 1'b1;
		tk(2);
		press[5] <= 1'b0;
		tk(3);
		chk("count_resume", {ctl.cnt_cleared, ctl.count}, 17'h00001);
		// normally closed contact and a glitch shorter than three scans
		wb(1, REG_FUNC, fw(FN_FREQ_SEC, 5'h0, 5'h0, 5'h0, 5'h0, 5'h0));
		wb(1, REG_SCAN, 32'h3);
		wb(1, REG_POL, 32'h1);
		nc <= 6'h01;
		tk(5);
		chk("nc_rest", ctl.freq_sec, 1'b0);
		press[0] <= 1'b1;
		tk(2);
		press[0] <= 1'b0;
		tk(5);
		chk("glitch", ctl.freq_sec, 1'b0);
		press[0] <= 1'b1;
		tk(5);
		chk("nc_press", ctl.freq_sec, 1'b1);
		wb(0, REG_STAT, 0);
		chk("stat_act", q[5:0], 6'h01);
		press[0] <= 1'b0;
		nc <= 6'h00;
		wb(1, REG_POL, 32'h0);
		wb(1, REG_SCAN, 32'h1);
		tk(5);
		// continuous up, then both keys together
		wb(1, REG_FUNC, fw(FN_UP, FN_DOWN, 5'h0, 5'h0, 5'h0, 5'h0));
		wb(1, REG_UPDN, {14'h0, HOLD_KEEP, 16'h0});
		press <= 6'h01;
		tk(10);
		chk("ramp_up", ctl.setpoint > 16'd5 && ctl.setpoint < 16'd15, 1'b1);
		press <= 6'h03;
		tk(2);
		sp = ctl.setpoint;
		tk(5);
		chk("both_keys", ctl.setpoint, sp);
		press <= 6'h00;
		// step of 5, held past the hold time
		wb(1, REG_UPDN, {14'h0, HOLD_KEEP, 16'h0005});
		tk(2);
		sp = ctl.setpoint;
		press <= 6'h01;
		tk(900);
		chk("one_step", ctl.setpoint, sp + 16'd5);
		tk(110);
		chk("held_ramp", ctl.setpoint > sp + 16'd5, 1'b1);
		press <= 6'h00;
		// zero at stop
		wb(1, REG_UPDN, {14'h0, HOLD_ZERO, 16'h0});
		drv.run <= 1'b1;
		tk(2);
		press <= 6'h01;
		tk(3);
		chk("zero_run_up", ctl.setpoint != 16'h0, 1'b1);
		press <= 6'h00;
		drv.run <= 1'b0;
		tk(2);
		chk("zero_stop", ctl.setpoint, 16'h0);
		// start at preset, save at stop, keys idle when stopped
		wb(1, REG_PRESET, 32'h04D2);
		wb(1, REG_UPDN, {14'h0, HOLD_STOP_IDLE, 16'h0});
		drv.run <= 1'b1;
		tk(2);
		chk("preset_start", ctl.setpoint, 16'h04D2);
		press <= 6'h01;
		tk(5);
		press <= 6'h00;
		tk(2);
		sp = ctl.setpoint;
		drv.run <= 1'b0;
		tk(2);
		wb(0, REG_PRESET, 0);
		chk("preset_save", q[15:0], sp);
		press <= 6'h01;
		tk(5);
		chk("keys_idle", ctl.setpoint, sp);
		press <= 6'h00;
		// current reached, 50 ticks on and 50 ticks off delay
		wb(1, REG_RELAY, {28'h0, RC_CURRENT});
		wb(1, REG_CURR, 32'h00010064);
		drv.iout <= 16'd200;
		tk(40);
		chk("cur_early", r1, 1'b0);
		tk(20);
		chk("cur_on", r1, 1'b1);
		drv.iout <= 16'd0;
		tk(40);
		chk("off_delay", r1, 1'b1);
		tk(20);
		chk("cur_off", r1, 1'b0);
		// traverse around center 2000, up 200, down 100
		wb(1, REG_FUNC, fw(FN_TRAV_EN, FN_TRAV_UP, FN_TRAV_DN, 5'h0, 5'h0, 5'h0));
		wb(1, REG_TRAV, 32'h07D0);
		wb(1, REG_TDEV, 32'h006400C8);
		drv.run <= 1'b1;
		drv.fout <= 16'd1000;
		press <= 6'h01;
		tk(2);
		chk("approach", {ctl.trav_active, ctl.ramp}, {1'b0, RAMP_ACC});
		drv.fout <= 16'd2000;
		repeat (3) @(posedge clk_i);
		chk("trav_on", {ctl.trav_active, ctl.ramp}, {1'b1, RAMP_TDN});
		press <= 6'h03;
		tk(2);
		chk("shift_up", {ctl.trav_center, ctl.ramp}, {16'd2200, RAMP_TUP});
		press <= 6'h07;
		tk(2);
		chk("both_dev", ctl.trav_center, 16'd2000);
		press <= 6'h05;
		tk(2);
		chk("shift_dn", ctl.trav_center, 16'd1900);
		press <= 6'h00;
		tk(2);
		chk("trav_off", {ctl.trav_active, ctl.ramp}, {1'b0, RAMP_DEC});
		// enable held on a stopped drive: traverse must not start
		drv.run <= 1'b0;
		press <= 6'h01;
		tk(2);
		chk("trav_stopped", {ctl.trav_active, ctl.ramp}, {1'b0, RAMP_DEC});
		// mid-run reset brings every output back to its reset value
		press <= 6'h00;
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk("ctl_rst2", {31'h0, |ctl}, 32'h0);
		chk("relay_rst2", {r1, r2}, 2'b00);
		wb(0, REG_SCAN, 0);
		chk("scan_rst2", q, 32'h1);
		test_done;
	end
endmodule
`default_nettype wire
